// ==== bench/ipff_capture_model.sv ====
// Capture controller model driving the port tri-state pin
`timescale 1ns/100ps
`default_nettype none
module ipff_capture_model (
   input  wire logic port_clk_i,
   input  wire logic level_i,
   output logic      tri_pin_o
);
   // The controller moves its enable only on its own clock edge
   logic pin_ff = 1'h0;
   always_ff @(posedge port_clk_i) pin_ff <= level_i;
   assign tri_pin_o = pin_ff;
endmodule : ipff_capture_model
`default_nettype wire

// ==== bench/ipff_monitor.sv ====
// Concurrent checks on the image port flag and enable block
`timescale 1ns/100ps
`default_nettype none
module ipff_monitor
   import ipff_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       nrst_i,
   input wire logic       port_clk_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       gated_clock_mode_bit_i,
   input wire logic [5:0] fifo_level_i,
   input wire logic       data_valid_i,
   input wire logic       port_tristate_pin_i,
   input wire logic       port_output_clock_o,
   input wire logic       out_clk_fine_dly_o,
   input wire logic       data_qualifier_out_o,
   input wire logic       dq_fine_dly_o,
   input wire logic       port_oe_o,
   input wire logic       fifo_almost_empty_flag_o,
   input wire logic       fifo_almost_full_flag_o
);
   logic [7:0] f86_ff, f87_ff, quiet_ff;
   logic [3:0] pin_ff;
   logic       gm_ff, ok;
   logic [1:0] m;
   assign ok = quiet_ff == 8'hFF;
   assign m = f87_ff[1:0];
   // Config crosses by handshake; checks pause until it has surely landed
   always_ff @(posedge clk_i) begin
      gm_ff <= gated_clock_mode_bit_i;
      if (!nrst_i || reg_wr_i || gm_ff != gated_clock_mode_bit_i)
         quiet_ff <= 8'h00;
      else if (!ok)
         quiet_ff <= quiet_ff + 8'h01;
   end
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         f86_ff <= 8'h00;
         f87_ff <= 8'h00;
      end else if (reg_wr_i) begin
         if (reg_addr_i == REG_FLAG_CTRL) f86_ff <= reg_wdata_i;
         if (reg_addr_i == REG_PHASE_EN) f87_ff <= reg_wdata_i;
      end
   end
   always_ff @(posedge port_clk_i) pin_ff <= {pin_ff[2:0], port_tristate_pin_i};
   function automatic logic lo(input logic [1:0] s, input logic [5:0] l);
      return l < ((s == 2'h3) ? 6'h01 : (6'h10 >> s));
   endfunction : lo
   function automatic logic hi(input logic [1:0] s, input logic [5:0] l);
      return l >= ((s == 2'h3) ? 6'h20 : 6'h20 - (6'h10 >> s));
   endfunction : hi
   a_empty_level:
   assert property (@(posedge port_clk_i) disable iff (!ok)
      fifo_almost_empty_flag_o == lo(f86_ff[1:0], $past(fifo_level_i)))
      else $error("almost empty flag wrong");
   a_full_level:
   assert property (@(posedge port_clk_i) disable iff (!ok)
      fifo_almost_full_flag_o == hi(f86_ff[3:2], $past(fifo_level_i)))
      else $error("almost full flag wrong");
   a_oe_mode:
   assert property (@(posedge port_clk_i) disable iff (!ok)
      (&pin_ff || ~|pin_ff) |-> port_oe_o == (m[1] ? pin_ff[0] == m[0] : m[0]))
      else $error("output enable wrong");
   a_clock_divide:
   assert property (@(posedge port_clk_i) disable iff (!ok) $changed(port_output_clock_o))
      else $error("output clock stalled");
   a_gated_phase:
   assert property (@(posedge port_clk_i) disable iff (!ok) gated_clock_mode_bit_i |->
      data_qualifier_out_o == ($past(data_valid_i)
      && (port_output_clock_o ^ f87_ff[4] ^ f87_ff[6])))
      else $error("gated clock phase wrong");
   a_plain_qual:
   assert property (@(posedge port_clk_i) disable iff (!ok) !gated_clock_mode_bit_i
      |-> data_qualifier_out_o == $past(data_valid_i))
      else $error("qualifier wrong");
   a_out_fine:
   assert property (@(posedge port_clk_i) disable iff (!ok) out_clk_fine_dly_o == f87_ff[5])
      else $error("clock fine delay wrong");
   a_dq_fine:
   assert property (@(posedge port_clk_i) disable iff (!ok)
      dq_fine_dly_o == (gated_clock_mode_bit_i && f87_ff[7]))
      else $error("qualifier fine delay wrong");
   cover property (@(posedge port_clk_i) ok && fifo_almost_full_flag_o);
   cover property (@(posedge port_clk_i) ok && m[1] && port_oe_o);
   cover property (@(posedge port_clk_i) ok && dq_fine_dly_o);
endmodule : ipff_monitor
bind ipff_top ipff_monitor i_mon (.clk_i, .nrst_i, .port_clk_i, .reg_addr_i, .reg_wr_i,
   .reg_wdata_i, .gated_clock_mode_bit_i, .fifo_level_i, .data_valid_i, .port_tristate_pin_i,
   .port_output_clock_o, .out_clk_fine_dly_o, .data_qualifier_out_o, .dq_fine_dly_o,
   .port_oe_o, .fifo_almost_empty_flag_o, .fifo_almost_full_flag_o);
`default_nettype wire

// ==== bench/test_ipff_top.sv ====
// Self-checking bench for the image port flag and enable block
`timescale 1ns/100ps
`default_nettype none
module test_ipff_top import ipff_pkg::*;;
   logic clk_i = 1'h0, nrst_i = 1'h0, port_clk_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
   logic gated_clock_mode_bit_i = 1'h0, data_valid_i = 1'h0, pin_high = 1'h0;
   logic gp0_alt_i = 1'h0, gp1_alt_i = 1'h1;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic [1:0] gp0_sel_i = 2'h0, gp1_sel_i = 2'h0;
   logic [5:0] fifo_level_i = 6'h00;
   logic port_output_clock_o, out_clk_fine_dly_o, data_qualifier_out_o, dq_fine_dly_o;
   logic port_oe_o, general_out_zero_o, general_out_one_o;
   logic fifo_almost_empty_flag_o, fifo_almost_full_flag_o;
   wire  port_tristate_pin_i;
   int   fails = 0, n_tests = 0;
   initial forever #5 clk_i = ~clk_i;
   initial begin
      #7;
      forever #24 port_clk_i = ~port_clk_i;
   end
   ipff_top i_dut (.*);
   ipff_capture_model i_ctl (.port_clk_i(port_clk_i), .level_i(pin_high),
      .tri_pin_o(port_tristate_pin_i));
   task automatic chk(input string nm, input logic [7:0] s, e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic pw(input int n);
      repeat (n) @(posedge port_clk_i);
      #1;
   endtask : pw
   // Waits out the handshake so the port side sees the new setting
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_i) #1;
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'h1;
      @(posedge clk_i) #1;
      reg_wr_i = 1'h0;
      pw(60);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i) #1;
      reg_addr_i = a;
      reg_rd_i = 1'h1;
      @(posedge clk_i) #1;
      reg_rd_i = 1'h0;
      d = reg_rdata_o;
   endtask : rd
   task automatic t_regs;
      logic [7:0] d;
      rd(REG_FLAG_CTRL, d);
      chk("flag ctrl rst", d, FLAG_CTRL_RST);
      rd(REG_PHASE_EN, d);
      chk("phase en rst", d, PHASE_EN_RST);
      wr(REG_FLAG_CTRL, 8'hC6);
      wr(REG_PHASE_EN, 8'h3C);
      wr(REG_STATUS, 8'hFF);
      rd(REG_FLAG_CTRL, d);
      chk("flag ctrl", d, 8'hC6);
      rd(REG_PHASE_EN, d);
      chk("phase en", d, 8'h3C);
      rd(8'h90, d);
      chk("unmapped", d, RDATA_UNMAPPED);
      rd(REG_STATUS, d);
      chk("status wr", d, 8'h00);
   endtask : t_regs
   task automatic t_flags;
      logic [5:0] et[4] = '{6'h10, 6'h08, 6'h04, 6'h01};
      logic [5:0] ft[4] = '{6'h10, 6'h18, 6'h1C, 6'h20};
      logic [5:0] lv[4];
      for (int s = 0; s < 4; s++) begin
         wr(REG_FLAG_CTRL, 8'(s * 5));
         lv = '{et[s] - 6'h01, et[s], ft[s] - 6'h01, ft[s]};
         foreach (lv[i]) begin
            fifo_level_i = lv[i];
            pw(2);
            chk("empty", 8'(fifo_almost_empty_flag_o), 8'(lv[i] < et[s]));
            chk("full", 8'(fifo_almost_full_flag_o), 8'(lv[i] >= ft[s]));
         end
      end
   endtask : t_flags
   task automatic t_oe;
      logic [7:0] d;
      for (int m = 0; m < 4; m++) begin
         wr(REG_PHASE_EN, 8'(m));
         for (int p = 0; p < 2; p++) begin
            pin_high = p[0];
            pw(6);
            chk("oe", 8'(port_oe_o), 8'(m == 1 || (m > 1 && p == m - 2)));
            rd(REG_STATUS, d);
            chk("status", d, 8'(p << STATUS_TRI_BIT));
         end
      end
   endtask : t_oe
   task automatic t_phase;
      logic c;
      gated_clock_mode_bit_i = 1'h1;
      data_valid_i = 1'h1;
      wr(REG_PHASE_EN, 8'h51);
      c = port_output_clock_o;
      pw(1);
      chk("clk toggle", 8'(port_output_clock_o), 8'(!c));
      chk("gated", 8'(data_qualifier_out_o), 8'(port_output_clock_o));
      chk("fine", 8'({out_clk_fine_dly_o, dq_fine_dly_o}), 8'h00);
      data_valid_i = 1'h0;
      pw(2);
      chk("gated idle", 8'(data_qualifier_out_o), 8'h00);
      data_valid_i = 1'h1;
      wr(REG_PHASE_EN, 8'h41);
      chk("gated inv", 8'(data_qualifier_out_o), 8'(!port_output_clock_o));
      wr(REG_PHASE_EN, 8'hA1);
      chk("fine on", 8'({out_clk_fine_dly_o, dq_fine_dly_o}), 8'h03);
      gated_clock_mode_bit_i = 1'h0;
      wr(REG_PHASE_EN, 8'hE1);
      chk("fine plain", 8'({out_clk_fine_dly_o, dq_fine_dly_o}), 8'h02);
      pw(1);
      chk("plain qual", 8'(data_qualifier_out_o), 8'h01);
      pw(1);
      chk("plain qual next", 8'(data_qualifier_out_o), 8'h01);
      data_valid_i = 1'h0;
      pw(2);
      chk("plain idle", 8'(data_qualifier_out_o), 8'h00);
   endtask : t_phase
   task automatic t_gp;
      gp0_sel_i = GP_SEL_FULL;
      gp1_sel_i = GP_SEL_EMPTY;
      fifo_level_i = 6'h20;
      wr(REG_FLAG_CTRL, 8'h30);
      chk("gp full", 8'({general_out_zero_o, general_out_one_o}), 8'h02);
      fifo_level_i = 6'h00;
      pw(2);
      chk("gp empty", 8'({general_out_zero_o, general_out_one_o}), 8'h01);
      fifo_level_i = 6'h20;
      wr(REG_FLAG_CTRL, 8'h00);
      chk("gp alt", 8'({general_out_zero_o, general_out_one_o}), 8'h01);
      gp0_sel_i = 2'h1;
      gp1_sel_i = 2'h0;
      wr(REG_FLAG_CTRL, 8'h30);
      chk("gp other code", 8'({general_out_zero_o, general_out_one_o}), 8'h01);
      gp0_alt_i = 1'h1;
      gp1_alt_i = 1'h0;
      pw(2);
      chk("gp alt swap", 8'({general_out_zero_o, general_out_one_o}), 8'h02);
   endtask : t_gp
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   initial begin
      // Port side reset is stretched inside the block
      repeat (6) @(posedge clk_i);
      #1 nrst_i = 1'h1;
      t_regs();
      t_flags();
      t_oe();
      t_phase();
      t_gp();
      stop_test();
   end
   initial begin
      #150000;
      fails++;
      stop_test();
   end
endmodule : test_ipff_top
`default_nettype wire

// ==== rtl/ipff_pkg.sv ====
// Constants shared by the image port FIFO flag and clock enable block
package ipff_pkg;

   // Register subaddresses
   localparam logic [7:0] REG_FLAG_CTRL   = 8'h86;
   localparam logic [7:0] REG_PHASE_EN    = 8'h87;
   localparam logic [7:0] REG_STATUS      = 8'h8F;

   // Reset values (none documented, cleared to zero)
   localparam logic [7:0] FLAG_CTRL_RST   = 8'h00;
   localparam logic [7:0] PHASE_EN_RST    = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

   // Flag control field positions
   localparam int EMPTY_SEL_LSB           = 0;
   localparam int FULL_SEL_LSB            = 2;
   localparam int GP1_FLAG_BIT            = 4;
   localparam int GP0_FLAG_BIT            = 5;

   // Phase and enable field positions
   localparam int PORT_EN_LSB             = 0;
   localparam int OUT_PHASE_LSB           = 4;
   localparam int GATED_PHASE_LSB         = 6;

   // Status bit carrying the tri-state pin level
   localparam int STATUS_TRI_BIT          = 6;

   // FIFO levels in double words
   localparam logic [5:0] LVL_0           = 6'h00;
   localparam logic [5:0] LVL_4           = 6'h04;
   localparam logic [5:0] LVL_8           = 6'h08;
   localparam logic [5:0] LVL_16          = 6'h10;
   localparam logic [5:0] LVL_24          = 6'h18;
   localparam logic [5:0] LVL_28          = 6'h1C;
   localparam logic [5:0] LVL_32          = 6'h20;

   // Threshold select codes
   localparam logic [1:0] SEL_0           = 2'h0;
   localparam logic [1:0] SEL_1           = 2'h1;
   localparam logic [1:0] SEL_2           = 2'h2;
   localparam logic [1:0] SEL_3           = 2'h3;

   // Port enable modes
   localparam logic [1:0] EN_OFF          = 2'h0;
   localparam logic [1:0] EN_ON           = 2'h1;
   localparam logic [1:0] EN_PIN_LOW      = 2'h2;
   localparam logic [1:0] EN_PIN_HIGH     = 2'h3;

   // General output select low bits that pick the level flags
   localparam logic [1:0] GP_SEL_FULL     = 2'h2;
   localparam logic [1:0] GP_SEL_EMPTY    = 2'h3;

   // Fine phase step, realised by the pad delay cell
   localparam int FINE_SHIFT_NS           = 3;

   // Configuration word crossing into the port clock domain
   localparam int CFG_W                   = 21;

endpackage : ipff_pkg

// ==== rtl/ipff_sync.sv ====
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module ipff_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;
endmodule : ipff_sync
`default_nettype wire

// ==== rtl/ipff_top.sv ====
// Image port FIFO flag levels, clock phase and output enable control
`timescale 1ns/100ps
`default_nettype none
module ipff_top
   import ipff_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       port_clk_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       gated_clock_mode_bit_i,
   input  wire logic [1:0] gp0_sel_i,
   input  wire logic [1:0] gp1_sel_i,
   input  wire logic [5:0] fifo_level_i,
   input  wire logic       data_valid_i,
   input  wire logic       gp0_alt_i,
   input  wire logic       gp1_alt_i,
   input  wire logic       port_tristate_pin_i,
   output logic            port_output_clock_o,
   output logic            out_clk_fine_dly_o,
   output logic            data_qualifier_out_o,
   output logic            dq_fine_dly_o,
   output logic            port_oe_o,
   output logic            general_out_zero_o,
   output logic            general_out_one_o,
   output logic            fifo_almost_empty_flag_o,
   output logic            fifo_almost_full_flag_o
);

   // Phase field decode: bit 0 is the half cycle shift, bit 1 the fine step
   function automatic logic phase_half(input logic [1:0] sel);
      phase_half = sel[0];
   endfunction : phase_half

   function automatic logic phase_fine(input logic [1:0] sel);
      phase_fine = sel[1];
   endfunction : phase_fine

   // Flag codes replace the alternate source only while the flag bit is set
   function automatic logic gp_pick(input logic       flag_sel,
                                    input logic [1:0] sel,
                                    input logic       full,
                                    input logic       empty,
                                    input logic       alt);
      if (flag_sel && sel == GP_SEL_FULL) begin
         gp_pick = full;
      end else if (flag_sel && sel == GP_SEL_EMPTY) begin
         gp_pick = empty;
      end else begin
         gp_pick = alt;
      end
   endfunction : gp_pick

   // Register side, clk_i domain
   logic [7:0]       flag_ctrl_ff;
   logic [7:0]       phase_en_ff;
   logic [7:0]       rdata_ff;
   logic [7:0]       nxt_rdata;
   logic             tri_reg_sync;
   logic [CFG_W-1:0] cfg_src;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         flag_ctrl_ff <= FLAG_CTRL_RST;
      end else if (reg_wr_i && reg_addr_i == REG_FLAG_CTRL) begin
         flag_ctrl_ff <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         phase_en_ff <= PHASE_EN_RST;
      end else if (reg_wr_i && reg_addr_i == REG_PHASE_EN) begin
         phase_en_ff <= reg_wdata_i;
      end
   end

   ipff_sync #(.W(1)) u_tri_reg_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .d_i    (port_tristate_pin_i),
      .q_o    (tri_reg_sync)
   );

   always_comb begin
      nxt_rdata = RDATA_UNMAPPED;
      case (reg_addr_i)
         REG_FLAG_CTRL: nxt_rdata = flag_ctrl_ff;
         REG_PHASE_EN:  nxt_rdata = phase_en_ff;
         REG_STATUS: begin
            // Pin level is shown whatever the enable mode
            nxt_rdata[STATUS_TRI_BIT] = tri_reg_sync;
         end
         default:       nxt_rdata = RDATA_UNMAPPED;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_ff <= RDATA_UNMAPPED;
      end else if (reg_rd_i) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_o = rdata_ff;

   // Mode bit and external selects are quasi-static and travel with the registers
   assign cfg_src = {gated_clock_mode_bit_i, gp1_sel_i, gp0_sel_i, phase_en_ff, flag_ctrl_ff};

   // Port side, port_clk_i domain
   logic             port_nrst;
   logic [CFG_W-1:0] cfg;
   logic             tri_port_sync;

   // Port side reset is stretched to sixteen clk_i cycles; a short reset pulse
   // could otherwise fall between two port clock edges and be missed there
   logic [3:0] rst_hold_ff;
   logic       port_nrst_req_ff;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rst_hold_ff      <= 4'h0;
         port_nrst_req_ff <= 1'h0;
      end else begin
         if (!(&rst_hold_ff)) begin
            rst_hold_ff <= rst_hold_ff + 4'h1;
         end
         port_nrst_req_ff <= &rst_hold_ff;
      end
   end

   // Reset release is synchronised so the port flops leave reset together
   ipff_sync #(.W(1)) u_rst_sync (
      .clk_i  (port_clk_i),
      .nrst_i (1'b1),
      .d_i    (port_nrst_req_ff),
      .q_o    (port_nrst)
   );

   ipff_xfer u_xfer (
      .src_clk_i  (clk_i),
      .src_nrst_i (nrst_i),
      .src_data_i (cfg_src),
      .dst_clk_i  (port_clk_i),
      .dst_nrst_i (port_nrst),
      .dst_data_o (cfg)
   );

   ipff_sync #(.W(1)) u_tri_port_sync (
      .clk_i  (port_clk_i),
      .nrst_i (port_nrst),
      .d_i    (port_tristate_pin_i),
      .q_o    (tri_port_sync)
   );

   logic [1:0] empty_sel;
   logic [1:0] full_sel;
   logic       gp0_flag_sel;
   logic       gp1_flag_sel;
   logic [1:0] port_en_mode;
   logic [1:0] out_phase;
   logic [1:0] gated_phase;
   logic [1:0] gp0_sel;
   logic [1:0] gp1_sel;
   logic       gated_mode;

   assign empty_sel    = cfg[EMPTY_SEL_LSB +: 2];
   assign full_sel     = cfg[FULL_SEL_LSB +: 2];
   assign gp1_flag_sel = cfg[GP1_FLAG_BIT];
   assign gp0_flag_sel = cfg[GP0_FLAG_BIT];
   assign port_en_mode = cfg[8 + PORT_EN_LSB +: 2];
   assign out_phase    = cfg[8 + OUT_PHASE_LSB +: 2];
   assign gated_phase  = cfg[8 + GATED_PHASE_LSB +: 2];
   assign gp0_sel      = cfg[16 +: 2];
   assign gp1_sel      = cfg[18 +: 2];
   assign gated_mode   = cfg[20];

   // Level flags
   logic empty_ff;
   logic full_ff;
   logic nxt_empty;
   logic nxt_full;

   always_comb begin
      case (empty_sel)
         SEL_0:   nxt_empty = fifo_level_i < LVL_16;
         SEL_1:   nxt_empty = fifo_level_i < LVL_8;
         SEL_2:   nxt_empty = fifo_level_i < LVL_4;
         default: nxt_empty = fifo_level_i == LVL_0;
      endcase
   end

   always_comb begin
      case (full_sel)
         SEL_0:   nxt_full = fifo_level_i >= LVL_16;
         SEL_1:   nxt_full = fifo_level_i >= LVL_24;
         SEL_2:   nxt_full = fifo_level_i >= LVL_28;
         default: nxt_full = fifo_level_i == LVL_32;
      endcase
   end

   // Plain compare each cycle; a count hovering at the edge will chatter
   always_ff @(posedge port_clk_i) begin
      if (!port_nrst) begin
         empty_ff <= 1'b0;
         full_ff  <= 1'b0;
      end else begin
         empty_ff <= nxt_empty;
         full_ff  <= nxt_full;
      end
   end

   assign fifo_almost_empty_flag_o = empty_ff;
   assign fifo_almost_full_flag_o  = full_ff;

   // General outputs: the flags replace the alternate source on matching codes
   logic gp0_ff;
   logic gp1_ff;

   always_ff @(posedge port_clk_i) begin
      if (!port_nrst) begin
         gp0_ff <= 1'b0;
         gp1_ff <= 1'b0;
      end else begin
         gp0_ff <= gp_pick(gp0_flag_sel, gp0_sel, nxt_full, nxt_empty, gp0_alt_i);
         gp1_ff <= gp_pick(gp1_flag_sel, gp1_sel, nxt_full, nxt_empty, gp1_alt_i);
      end
   end

   assign general_out_zero_o = gp0_ff;
   assign general_out_one_o  = gp1_ff;

   // Output clock is port clock divided by two; half shift inverts its phase
   logic div_ff;
   logic out_clk_ff;
   logic out_fine_ff;

   always_ff @(posedge port_clk_i) begin
      if (!port_nrst) begin
         div_ff      <= 1'b0;
         out_clk_ff  <= 1'b0;
         out_fine_ff <= 1'b0;
      end else begin
         div_ff      <= ~div_ff;
         out_clk_ff  <= ~div_ff ^ phase_half(out_phase);
         // Fine step is only a pad delay request, not a logic delay
         out_fine_ff <= phase_fine(out_phase);
      end
   end

   assign port_output_clock_o = out_clk_ff;
   assign out_clk_fine_dly_o  = out_fine_ff;

   // Qualifier: gated clock in gated mode, plain valid otherwise
   logic dq_ff;
   logic dq_fine_ff;

   always_ff @(posedge port_clk_i) begin
      if (!port_nrst) begin
         dq_ff      <= 1'b0;
         dq_fine_ff <= 1'b0;
      end else if (gated_mode) begin
         dq_ff      <= data_valid_i & (~div_ff ^ phase_half(gated_phase));
         dq_fine_ff <= phase_fine(gated_phase);
      end else begin
         dq_ff      <= data_valid_i;
         dq_fine_ff <= 1'b0;
      end
   end

   assign data_qualifier_out_o = dq_ff;
   assign dq_fine_dly_o        = dq_fine_ff;

   // Output enable
   logic oe_ff;

   always_ff @(posedge port_clk_i) begin
      if (!port_nrst) begin
         oe_ff <= 1'b0;
      end else begin
         case (port_en_mode)
            EN_OFF:      oe_ff <= 1'b0;
            EN_ON:       oe_ff <= 1'b1;
            EN_PIN_LOW:  oe_ff <= ~tri_port_sync;
            EN_PIN_HIGH: oe_ff <= tri_port_sync;
            default:     oe_ff <= 1'b0;
         endcase
      end
   end

   assign port_oe_o = oe_ff;

endmodule : ipff_top
`default_nettype wire

// ==== rtl/ipff_xfer.sv ====
// Toggle handshake that carries a configuration word across clock domains
`timescale 1ns/100ps
`default_nettype none
module ipff_xfer
   import ipff_pkg::*;
(
   input  wire logic             src_clk_i,
   input  wire logic             src_nrst_i,
   input  wire logic [CFG_W-1:0] src_data_i,
   input  wire logic             dst_clk_i,
   input  wire logic             dst_nrst_i,
   output logic      [CFG_W-1:0] dst_data_o
);
   logic             req_ff;
   logic [CFG_W-1:0] hold_ff;
   logic             ack_ff;
   logic [CFG_W-1:0] dst_ff;
   logic             req_sync;
   logic             ack_sync;

   // Word is resent continuously, so any change lands within a few round trips
   always_ff @(posedge src_clk_i) begin
      if (!src_nrst_i) begin
         req_ff  <= 1'b0;
         hold_ff <= '0;
      end else if (ack_sync == req_ff) begin
         req_ff  <= ~req_ff;
         hold_ff <= src_data_i;
      end
   end

   ipff_sync #(.W(1)) u_req_sync (
      .clk_i  (dst_clk_i),
      .nrst_i (dst_nrst_i),
      .d_i    (req_ff),
      .q_o    (req_sync)
   );

   // Held word is stable while the toggle travels
   always_ff @(posedge dst_clk_i) begin
      if (!dst_nrst_i) begin
         ack_ff <= 1'b0;
         dst_ff <= '0;
      end else if (req_sync != ack_ff) begin
         ack_ff <= req_sync;
         dst_ff <= hold_ff;
      end
   end

   ipff_sync #(.W(1)) u_ack_sync (
      .clk_i  (src_clk_i),
      .nrst_i (src_nrst_i),
      .d_i    (ack_ff),
      .q_o    (ack_sync)
   );

   assign dst_data_o = dst_ff;
endmodule : ipff_xfer
`default_nettype wire
